//--- logic/link_master_defines.vh
// Register offsets, field positions and timing counts for the link master
`ifndef LINK_MASTER_DEFINES_VH
`define LINK_MASTER_DEFINES_VH

// Word indices of the shared word area; byte address is four times these
`define SWITCH_SNAPSHOT_IDX   8'h1A
`define LINK_COMMAND_IDX      8'h1B
`define LINK_STATUS_IDX       8'h1C
`define IRQ_STATUS_IDX        8'h30
`define IRQ_ENABLE_IDX        8'h31
`define IRQ_CLEAR_IDX         8'h32

// Writable and readable masks
`define SWITCH_MASK           16'h00FF
`define COMMAND_MASK          16'h0030
`define STATUS_MASK           16'h003F

// Command bits
`define CMD_SAVE_BIT          4
`define CMD_STOP_BIT          5

// Status bits
`define ST_LINK_ACTIVE_BIT    0
`define ST_INIT_DONE_BIT      1
`define ST_RUN_BIT            2
`define ST_SETUP_BIT          3
`define ST_SAVE_DONE_BIT      4
`define ST_LINK_STOPPED_BIT   5

// Interrupt events
`define IRQ_SAVE_DONE_BIT     0
`define IRQ_LINK_STOPPED_BIT  1
`define IRQ_INIT_DONE_BIT     2
`define IRQ_WIDTH             3

// Switch snapshot capture points, in cycles after reset release
`define SNAP_CAPTURE_AT       3'h4
`define SNAP_SETTLED          3'h5

// Non-volatile save duration in ns and derived cycles at 200 MHz
`define SAVE_TIME_NS          2000
`define CLK_PERIOD_NS         5
`define SAVE_CYCLES           ((`SAVE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- logic/pin_sync.v
// Three-stage synchroniser for pin inputs with agreement filter
`timescale 1ns/100ps
module pin_sync
#(
  parameter WIDTH = 8
)
(
  // Clock and reset
  input  wire             sys_clk,
  input  wire             arst_n,
  // Pins and filtered result
  input  wire [WIDTH-1:0] pin_in,
  output reg  [WIDTH-1:0] pin_out
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;

  // Stage one feeds stage two only; a change counts once two and three agree
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stage1  <= {WIDTH{1'b0}};
      stage2  <= {WIDTH{1'b0}};
      stage3  <= {WIDTH{1'b0}};
      pin_out <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3)
        pin_out <= stage3;
    end
  end

endmodule

//--- logic/save_engine.v
// Timed non-volatile save sequencer of the station detail words
`timescale 1ns/100ps
`include "link_master_defines.vh"
module save_engine
#(
  parameter SAVE_CYCLES = `SAVE_CYCLES
)
(
  // Clock and reset
  input  wire sys_clk,
  input  wire arst_n,
  // Control
  input  wire start,
  output wire busy,
  output reg  done
);

  localparam ST_IDLE = 2'b01;
  localparam ST_BUSY = 2'b10;

  reg [1:0]  state;
  reg [31:0] count;

  assign busy = state[1];

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= ST_IDLE;
      count <= 32'h00000000;
      done  <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (start)
          begin
            state <= ST_BUSY;
            count <= 32'h00000000;
          end
        end
        ST_BUSY:
        begin
          count <= count + 32'h00000001;
          if (count == SAVE_CYCLES - 1)
          begin
            state <= ST_IDLE;
            done  <= 1'b1;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

endmodule

//--- logic/link_master_regs.v
// Command and status register bank of the built-in field link master
// Operation
// (RL1) Switch bits 1..8 appear in bits 0..7
// (RL2) Switches captured once at power-on
// (RL3) Command bit 4 rising saves detail words
// (RL4) Program clears bit 4 after save done
// (RL5) Save happens only in setup mode
// (RL6) Save needed only after detail edits
// (RL7) Command bit 5 rising halts running link
// (RL8) Command bit 5 cleared resumes link
// (RL9) Status bit 0 shows link refreshing
// (RL10) Status bit 1 shows station info gathered
// (RL11) Station information acquired at power-on
// (RL12) Status bit 2 mirrors run lamp
// (RL13) Status bit 3 shows setup mode
// (RL14) Status bit 4 set at save end
// (RL15) Status bit 5 shows link halted
// (RL16) Prohibited bits read zero, writes ignored
`timescale 1ns/100ps
`include "link_master_defines.vh"
module link_master_regs
#(
  parameter SAVE_CYCLES = `SAVE_CYCLES
)
(
  // Clock and reset
  input  wire        sys_clk,
  input  wire        arst_n,
  // Avalon-MM slave
  input  wire [9:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // Device pins
  input  wire [7:0]  dip_switch,
  input  wire        setup_mode,
  input  wire        station_info_done,
  input  wire        run_ok,
  // Link engine
  output wire        link_enable,
  output wire        save_busy,
  // Interrupt
  output wire        irq
);

  // ------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------
  // Pins come from outside the clock domain; a lone glitch never counts
  localparam DIP_WIDTH  = 8;
  localparam FLAG_WIDTH = 3;

  wire [DIP_WIDTH-1:0]  dip_sync;
  wire [FLAG_WIDTH-1:0] flag_sync;

  pin_sync #(.WIDTH(DIP_WIDTH)) u_dip_sync
  (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .pin_in  (dip_switch),
    .pin_out (dip_sync)
  );

  pin_sync #(.WIDTH(FLAG_WIDTH)) u_flag_sync
  (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .pin_in  ({run_ok, station_info_done, setup_mode}),
    .pin_out (flag_sync)
  );

  wire setup_s = flag_sync[0];
  wire info_s  = flag_sync[1];
  wire run_s   = flag_sync[2];

  // ------------------------------------------------------------
  // Bus handshake
  // ------------------------------------------------------------
  // One wait cycle per access so read data is registered
  reg ack;

  wire req = (avs_read | avs_write) & ~ack;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      ack <= 1'b0;
    else
      ack <= req;
  end

  wire [7:0] word_idx = avs_address[9:2];
  wire       lo_en    = avs_byteenable[0];
  wire       hi_en    = avs_byteenable[1];
  wire       wr_go    = avs_write & req;
  wire       rd_go    = avs_read & req;

  function hit;
    input [7:0] idx;
    input [7:0] target;
    begin
      hit = (idx == target);
    end
  endfunction

  // ------------------------------------------------------------
  // Write strobes
  // ------------------------------------------------------------
  // Writes land at the first edge of an access; the wait serves reads
  wire cmd_wr;
  wire ien_wr;
  wire iclr_wr;

  assign cmd_wr  = wr_go & hit(word_idx, `LINK_COMMAND_IDX);
  assign ien_wr  = wr_go & lo_en & hit(word_idx, `IRQ_ENABLE_IDX);
  assign iclr_wr = wr_go & lo_en & hit(word_idx, `IRQ_CLEAR_IDX);

  // ------------------------------------------------------------
  // Switch snapshot
  // ------------------------------------------------------------
  // Capture waits for the synchroniser to settle, then freezes
  reg [15:0] switch_snapshot;
  reg [2:0]  capture_wait;

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      switch_snapshot <= 16'h0000;
      capture_wait    <= 3'h0;
    end
    else if (capture_wait != `SNAP_SETTLED)
    begin
      capture_wait <= capture_wait + 3'h1;
      if (capture_wait == `SNAP_CAPTURE_AT)
        switch_snapshot <= {8'h00, dip_sync}; // RL1 RL2
    end
  end

  // ------------------------------------------------------------
  // Command word
  // ------------------------------------------------------------
  reg [15:0] link_command_word;
  reg [15:0] next_command;

  always @*
  begin
    next_command = link_command_word;
    if (cmd_wr)
    begin
      if (lo_en)
        next_command[7:0] = avs_writedata[7:0];
      if (hi_en)
        next_command[15:8] = avs_writedata[15:8];
    end
    next_command = next_command & `COMMAND_MASK; // RL16
  end

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      link_command_word <= 16'h0000;
    else
      link_command_word <= next_command;
  end

  wire save_req = link_command_word[`CMD_SAVE_BIT];
  wire stop_req = link_command_word[`CMD_STOP_BIT];
  wire save_rise = next_command[`CMD_SAVE_BIT] & ~save_req;
  wire stop_rise = next_command[`CMD_STOP_BIT] & ~stop_req;

  // ------------------------------------------------------------
  // Non-volatile save
  // ------------------------------------------------------------
  // A request outside setup mode is dropped, not queued for later
  wire save_start = save_rise & setup_s; // RL3 RL5
  wire save_done_pulse;
  reg  save_done;

  save_engine #(.SAVE_CYCLES(SAVE_CYCLES)) u_save
  (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .start   (save_start),
    .busy    (save_busy),
    .done    (save_done_pulse)
  );

  // Done holds until the program drops the request; set wins
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      save_done <= 1'b0;
    else if (save_done_pulse)
      save_done <= 1'b1; // RL14
    else if (!save_req)
      save_done <= 1'b0; // RL14 RL4
  end

  // ------------------------------------------------------------
  // Data link stop and restart
  // ------------------------------------------------------------
  // A stop raised before the link runs waits to be raised again
  reg link_stopped;

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      link_stopped <= 1'b0;
    else if (stop_rise && link_enable)
      link_stopped <= 1'b1; // RL7
    else if (!stop_req)
      link_stopped <= 1'b0; // RL8
  end

  // Link refreshes only after station info is in and while not halted
  assign link_enable = info_s & ~link_stopped; // RL11

  // ------------------------------------------------------------
  // Status word
  // ------------------------------------------------------------
  reg [15:0] link_status_word;

  always @*
  begin
    link_status_word                       = 16'h0000;     // RL16
    link_status_word[`ST_LINK_ACTIVE_BIT]  = link_enable;  // RL9
    link_status_word[`ST_INIT_DONE_BIT]    = info_s;       // RL10
    link_status_word[`ST_RUN_BIT]          = run_s;        // RL12
    link_status_word[`ST_SETUP_BIT]        = setup_s;      // RL13
    link_status_word[`ST_SAVE_DONE_BIT]    = save_done;    // RL14
    link_status_word[`ST_LINK_STOPPED_BIT] = link_stopped; // RL15
  end

  // ------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------
  reg  [`IRQ_WIDTH-1:0] irq_status;
  reg  [`IRQ_WIDTH-1:0] irq_enable;
  reg                   info_d;
  reg                   stop_d;
  wire [`IRQ_WIDTH-1:0] irq_event;
  wire [`IRQ_WIDTH-1:0] irq_clear;

  assign irq_event[`IRQ_SAVE_DONE_BIT]    = save_done_pulse;
  assign irq_event[`IRQ_LINK_STOPPED_BIT] = link_stopped & ~stop_d;
  assign irq_event[`IRQ_INIT_DONE_BIT]    = info_s & ~info_d;
  assign irq_clear = iclr_wr ? avs_writedata[`IRQ_WIDTH-1:0] :
                               {`IRQ_WIDTH{1'b0}};

  // An event beats a clear in the same cycle so none is lost
  genvar g;
  generate
    for (g = 0; g < `IRQ_WIDTH; g = g + 1)
    begin : gen_irq
      always @(posedge sys_clk or negedge arst_n)
      begin
        if (!arst_n)
          irq_status[g] <= 1'b0;
        else if (irq_event[g])
          irq_status[g] <= 1'b1;
        else if (irq_clear[g])
          irq_status[g] <= 1'b0;
      end
    end
  endgenerate

  // Delayed copies feed the event edge detectors
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      info_d <= 1'b0;
      stop_d <= 1'b0;
    end
    else
    begin
      info_d <= info_s;
      stop_d <= link_stopped;
    end
  end

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      irq_enable <= {`IRQ_WIDTH{1'b0}};
    else if (ien_wr)
      irq_enable <= avs_writedata[`IRQ_WIDTH-1:0];
  end

  assign irq = |(irq_status & irq_enable);

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  reg [31:0] next_readdata;

  always @*
  begin
    next_readdata = 32'h00000000;
    case (word_idx)
      `SWITCH_SNAPSHOT_IDX:
      begin
        next_readdata = {16'h0000, switch_snapshot & `SWITCH_MASK}; // RL16
      end
      `LINK_COMMAND_IDX:
      begin
        next_readdata = {16'h0000, link_command_word};
      end
      `LINK_STATUS_IDX:
      begin
        next_readdata = {16'h0000, link_status_word & `STATUS_MASK};
      end
      `IRQ_STATUS_IDX:
      begin
        next_readdata = {29'h00000000, irq_status};
      end
      `IRQ_ENABLE_IDX:
      begin
        next_readdata = {29'h00000000, irq_enable};
      end
      // The clear register is write-only and reads as zero
      `IRQ_CLEAR_IDX:
      begin
        next_readdata = 32'h00000000;
      end
      default:
      begin
        next_readdata = 32'h00000000;
      end
    endcase
  end

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      avs_readdata <= 32'h00000000;
    // Only reads load it, so the last read data stands
    else if (rd_go)
      avs_readdata <= next_readdata;
  end

endmodule

//--- bench/link_master_regs_chk.sv
// Checker of bus timing, save length and link status of the register bank
`timescale 1ns/100ps
module link_master_regs_chk
#(
  parameter SAVE_CYCLES = 400
)
(
  // Clock and reset
  input wire        sys_clk,
  input wire        arst_n,
  // Bus
  input wire [9:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0]  avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  // Pins
  input wire [7:0]  dip_switch,
  input wire        setup_mode,
  input wire        station_info_done,
  input wire        run_ok,
  input wire        link_enable,
  input wire        save_busy,
  input wire        irq
);
  int busy_len;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // ----
  // Length of the running save
  // ----
  always @(posedge sys_clk or negedge arst_n)
    if (!arst_n)
      busy_len <= 0;
    else
      busy_len <= save_busy ? busy_len + 1 : 0;
  a_wait_one: assert property ($rose(avs_read || avs_write) |->
    avs_waitrequest ##1 !avs_waitrequest) else $error("bad wait");
  a_read_hold: assert property (!(avs_read && avs_waitrequest) |=>
    $stable(avs_readdata)) else $error("read data moved");
  a_upper_zero: assert property (avs_read && !avs_waitrequest |->
    avs_readdata[31:16] == 16'h0000) else $error("upper bits set");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest &&
    avs_address[9:2] == 8'h00 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_save_bound: assert property (busy_len <= SAVE_CYCLES)
    else $error("save too long");
  a_save_full: assert property ($fell(save_busy) |->
    busy_len == SAVE_CYCLES) else $error("save too short");
  a_save_cause: assert property ($rose(save_busy) |-> $past(avs_write) ||
    $past(avs_write, 2) || $past(avs_write, 3)) else $error("save uncaused");
  a_link_info: assert property (link_enable |->
    $past(station_info_done, 3)) else $error("link before info");
endmodule
bind link_master_regs link_master_regs_chk #(.SAVE_CYCLES(SAVE_CYCLES)) u_chk
  (.sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .dip_switch(dip_switch),
  .setup_mode(setup_mode), .station_info_done(station_info_done),
  .run_ok(run_ok), .link_enable(link_enable), .save_busy(save_busy),
  .irq(irq));

//--- bench/station_side.sv
// Remote station side: gathers station info after power-on, reports run
`timescale 1ns/100ps
module station_side
#(
  parameter INFO_DELAY = 20
)
(
  // Clock and reset
  input  wire sys_clk,
  input  wire arst_n,
  // Far side levels
  output reg  station_info_done,
  output reg  run_ok
);
  int cnt;
  always @(posedge sys_clk or negedge arst_n)
    if (!arst_n)
    begin
      cnt <= 0;
      station_info_done <= 1'b0;
      run_ok <= 1'b0;
    end
    else
    begin
      run_ok <= 1'b1;
      if (cnt < INFO_DELAY)
        cnt <= cnt + 1;
      else
        station_info_done <= 1'b1;
    end
endmodule

//--- bench/link_master_regs_bench.sv
// Self-checking bench of the link master register bank
`timescale 1ns/100ps
module link_master_regs_bench;
  logic sys_clk, arst_n, avs_read, avs_write, setup_mode;
  logic [9:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [7:0] dip_switch;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata_q;
  wire avs_waitrequest, info, run, link_enable, save_busy, irq;
  int n_errors, comparisons, i;
  link_master_regs #(.SAVE_CYCLES(10)) u_dut (.sys_clk(sys_clk),
    .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .dip_switch(dip_switch),
    .setup_mode(setup_mode), .station_info_done(info), .run_ok(run),
    .link_enable(link_enable), .save_busy(save_busy), .irq(irq));
  station_side u_far (.sys_clk(sys_clk), .arst_n(arst_n),
    .station_info_done(info), .run_ok(run));
  always #2.5 sys_clk = ~sys_clk;
  // ----
  // Shared tasks
  // ----
  task close_out;
    if (n_errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Request held until waitrequest is sampled low, then released
  task bus(input bit wr, input [7:0] idx, input [15:0] wd);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {16'h0000, wd};
    avs_read <= !wr;
    avs_write <= wr;
    for (i = 0; i < 8; i++)
    begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    if (i == 8)
    begin
      n_errors++;
      close_out;
    end
    avs_readdata_q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task rchk(input [7:0] idx, input [31:0] exp);
    bus(1'b0, idx, 16'h0000);
    check(avs_readdata_q, exp);
  endtask
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // ----
  // Scenarios
  // ----
  task t_switch;
    rchk(8'h1A, 32'hA5);
    dip_switch <= 8'h3C;
    bus(1'b1, 8'h1A, 16'hFFFF);
    tick(8);
    rchk(8'h1A, 32'hA5);
    rchk(8'h00, 32'h0);
    bus(1'b1, 8'h1B, 16'hFFCF);
    rchk(8'h1B, 32'h0);
    avs_byteenable <= 4'hE;
    bus(1'b1, 8'h1B, 16'h0010);
    avs_byteenable <= 4'hF;
    rchk(8'h1B, 32'h0);
    check(save_busy, 32'h0);
    rchk(8'h1C, 32'h0F);
  endtask
  task t_stop;
    bus(1'b1, 8'h31, 16'h0000);
    bus(1'b1, 8'h1B, 16'h0020);
    tick(2);
    rchk(8'h1C, 32'h2E);
    check(link_enable, 32'h0);
    check(irq, 32'h0);
    rchk(8'h30, 32'h6);
    bus(1'b1, 8'h31, 16'h0007);
    check(irq, 32'h1);
    bus(1'b1, 8'h32, 16'h0007);
    rchk(8'h30, 32'h0);
    check(irq, 32'h0);
    bus(1'b1, 8'h1B, 16'h0000);
    tick(2);
    rchk(8'h1C, 32'h0F);
    check(link_enable, 32'h1);
  endtask
  task t_save;
    bus(1'b1, 8'h1B, 16'h0010);
    rchk(8'h1C, 32'h0F);
    for (i = 0; i < 50 && save_busy !== 1'b0; i++)
      tick(1);
    if (i == 50)
    begin
      n_errors++;
      close_out;
    end
    tick(2);
    rchk(8'h1C, 32'h1F);
    check(irq, 32'h1);
    bus(1'b1, 8'h1B, 16'h0000);
    rchk(8'h1C, 32'h0F);
  endtask
  task t_no_setup;
    setup_mode <= 1'b0;
    tick(6);
    bus(1'b1, 8'h1B, 16'h0010);
    tick(20);
    check(save_busy, 32'h0);
    rchk(8'h1C, 32'h07);
    bus(1'b1, 8'h1B, 16'h0000);
  endtask
  initial
  begin
    sys_clk = 1'b0;
    arst_n = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    dip_switch = 8'hA5;
    avs_byteenable = 4'hF;
    setup_mode = 1'b1;
    tick(16);
    arst_n <= 1'b1;
    tick(30);
    t_switch;
    t_stop;
    t_save;
    t_no_setup;
    close_out;
  end
endmodule
